// *** design/tcu_pkg.sv ***
// Package: constants and types for the 8-bit timer/counter compare unit
package tcu_pkg;
   // ------------------------------------------------------------
   // Count limits
   // ------------------------------------------------------------
   localparam logic [7:0] TCU_BOTTOM = 8'h00;
   localparam logic [7:0] TCU_MAX = 8'hff;
   localparam logic [7:0] TCU_RESET_COUNT = 8'h00;
   localparam logic [7:0] TCU_RESET_COMPARE = 8'h00;
   // ------------------------------------------------------------
   // Tick source select
   // ------------------------------------------------------------
   localparam logic [2:0] TCU_SRC_NONE = 3'h0;
   localparam logic [2:0] TCU_SRC_DIRECT = 3'h1;
   localparam logic [2:0] TCU_SRC_DIV8 = 3'h2;
   localparam logic [2:0] TCU_SRC_DIV64 = 3'h3;
   localparam logic [2:0] TCU_SRC_DIV256 = 3'h4;
   localparam logic [2:0] TCU_SRC_DIV1024 = 3'h5;
   localparam logic [2:0] TCU_SRC_EXT_FALL = 3'h6;
   localparam logic [2:0] TCU_SRC_EXT_RISE = 3'h7;
   localparam logic [9:0] TCU_DIV8_MASK = 10'h007;
   localparam logic [9:0] TCU_DIV64_MASK = 10'h03f;
   localparam logic [9:0] TCU_DIV256_MASK = 10'h0ff;
   localparam logic [9:0] TCU_DIV1024_MASK = 10'h3ff;
   // ------------------------------------------------------------
   // Waveform modes
   // ------------------------------------------------------------
   localparam logic [2:0] TCU_WM_NORMAL = 3'h0;
   localparam logic [2:0] TCU_WM_PC_MAX = 3'h1;
   localparam logic [2:0] TCU_WM_CTC = 3'h2;
   localparam logic [2:0] TCU_WM_FAST_MAX = 3'h3;
   localparam logic [2:0] TCU_WM_PC_CMP = 3'h5;
   localparam logic [2:0] TCU_WM_FAST_CMP = 3'h7;
   // ------------------------------------------------------------
   // Output action modes
   // ------------------------------------------------------------
   localparam logic [1:0] TCU_OA_NONE = 2'h0;
   localparam logic [1:0] TCU_OA_TOGGLE = 2'h1;
   localparam logic [1:0] TCU_OA_CLEAR = 2'h2;
   localparam logic [1:0] TCU_OA_SET = 2'h3;
   localparam int TCU_CHANNELS = 2;

   // Control fields split across the two control registers
   typedef struct packed {
      logic [1:0] output_action_mode_a;
      logic [1:0] output_action_mode_b;
      logic waveform_mode_bit1;
      logic waveform_mode_bit0;
   } tcu_control_a_t;

   typedef struct packed {
      logic waveform_mode_bit2;
      logic [2:0] tick_source_select;
   } tcu_control_b_t;

   // CPU write port for one 8-bit register
   typedef struct packed {
      logic wr;
      logic [7:0] data;
   } tcu_wr_t;

   // Count direction state
   typedef enum logic {
      TCU_DIR_UP = 1'b0,
      TCU_DIR_DOWN = 1'b1
   } tcu_dir_t;
endpackage

// *** design/tcu_timer8.sv ***
// Module: 8-bit timer/counter with two compare channels
// Operation
// - Three-bit tick source select; zero stops the counter.
// - Each tick clears, increments or decrements the counter per mode.
// - CPU can read and write count value any time.
// - CPU count write beats clear and count in the same cycle.
// - Mode is three bits: two in control A, one in control B.
// - Overflow flag set at mode dependent point; usable as interrupt.
// - Comparator matches count against both compare values continuously.
// - A match sets its channel flag on the following tick.
// - Enabled flag requests interrupt; flag clears when interrupt is taken.
// - Writing one to a flag clears it; zero leaves it.
// - Waveform output from match, mode, action bits, top and bottom.
// - Compare values double buffered in PWM modes only.
// - Buffered value moves to active register at top, in both fast and phase correct modes.
// - CPU compare access hits buffer when buffered, else active register.
// - Force strobe in non-PWM modes acts like match without flag.
// - Count write suppresses matches in the next tick, even stopped.
// - Output state holds across waveform mode changes.
// - Output action bits are unbuffered and act immediately.
// - Top indication at sequence maximum, bottom indication at zero.
// - Bottom recognised when count becomes 0x00.
// - Maximum recognised when count becomes 0xFF.
// - Top is 0xFF or compare value A, chosen by mode.
// - Reset clears each channel output state to zero.
`timescale 1ns/1ps
`default_nettype none
module tcu_timer8
   import tcu_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire tcu_control_a_t control_a,
   input wire tcu_control_b_t control_b,
   input wire logic ext_tick,
   input wire tcu_wr_t count_wr,
   input wire tcu_wr_t compare_wr_a,
   input wire tcu_wr_t compare_wr_b,
   input wire logic [1:0] force_match_strobe,
   input wire logic [2:0] flag_clear_wr,
   input wire logic [2:0] irq_enable,
   input wire logic [2:0] irq_ack,
   output logic [7:0] count_value,
   output logic [7:0] compare_value_a,
   output logic [7:0] compare_value_b,
   output logic match_flag_a,
   output logic match_flag_b,
   output logic overflow_flag,
   output logic [2:0] irq_request,
   output logic wave_output_a,
   output logic wave_output_b,
   output logic count_down
);
   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   wire logic [2:0] waveform_mode = {control_b.waveform_mode_bit2,
      control_a.waveform_mode_bit1, control_a.waveform_mode_bit0};
   wire logic is_fast = (waveform_mode == TCU_WM_FAST_MAX) ||
      (waveform_mode == TCU_WM_FAST_CMP);
   wire logic is_pc = (waveform_mode == TCU_WM_PC_MAX) || (waveform_mode == TCU_WM_PC_CMP);
   wire logic is_pwm = is_fast || is_pc;
   wire logic top_is_cmp = (waveform_mode == TCU_WM_CTC) ||
      (waveform_mode == TCU_WM_PC_CMP) || (waveform_mode == TCU_WM_FAST_CMP);
   wire logic [1:0] action [TCU_CHANNELS];
   assign action[0] = control_a.output_action_mode_a;
   assign action[1] = control_a.output_action_mode_b;

   // ------------------------------------------------------------
   // Tick source and prescaler
   // ------------------------------------------------------------
   logic [9:0] presc_q;
   logic ext_q;
   logic tick;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         presc_q <= 10'h000;
         ext_q <= 1'b0;
      end else begin
         presc_q <= presc_q + 10'h001;
         ext_q <= ext_tick;
      end
   end
   always_comb begin
      case (control_b.tick_source_select)
         TCU_SRC_NONE: tick = 1'b0;
         TCU_SRC_DIRECT: tick = 1'b1;
         TCU_SRC_DIV8: tick = (presc_q & TCU_DIV8_MASK) == TCU_DIV8_MASK;
         TCU_SRC_DIV64: tick = (presc_q & TCU_DIV64_MASK) == TCU_DIV64_MASK;
         TCU_SRC_DIV256: tick = (presc_q & TCU_DIV256_MASK) == TCU_DIV256_MASK;
         TCU_SRC_DIV1024: tick = (presc_q & TCU_DIV1024_MASK) == TCU_DIV1024_MASK;
         TCU_SRC_EXT_FALL: tick = ext_q && !ext_tick;
         default: tick = !ext_q && ext_tick;
      endcase
   end

   // ------------------------------------------------------------
   // Counter unit
   // ------------------------------------------------------------
   logic [7:0] count_q;
   logic [7:0] active_q [TCU_CHANNELS];
   logic [7:0] buffer_q [TCU_CHANNELS];
   tcu_dir_t dir_q;
   logic block_q;
   wire logic [7:0] top_value = top_is_cmp ? active_q[0] : TCU_MAX;
   wire logic at_top = (count_q == top_value);
   wire logic at_bottom = (count_q == TCU_BOTTOM);
   wire logic at_max = (count_q == TCU_MAX);
   wire logic dir_down = is_pc && (dir_q == TCU_DIR_DOWN || at_top) && !at_bottom;
   logic [7:0] count_d;
   always_comb begin
      count_d = count_q;
      if (count_wr.wr) begin
         count_d = count_wr.data;
      end else if (tick) begin
         if (!is_pc && top_is_cmp && at_top) begin
            count_d = TCU_BOTTOM;
         end else if (is_fast && at_top) begin
            count_d = TCU_BOTTOM;
         end else if (dir_down) begin
            count_d = count_q - 8'h01;
         end else begin
            count_d = count_q + 8'h01;
         end
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count_q <= TCU_RESET_COUNT;
         dir_q <= TCU_DIR_UP;
      end else begin
         count_q <= count_d;
         if (tick && !count_wr.wr) begin
            dir_q <= dir_down ? TCU_DIR_DOWN : TCU_DIR_UP;
         end
         if (!is_pc) begin
            dir_q <= TCU_DIR_UP;
         end
      end
   end

   // Count write blocks matches through the next tick
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         block_q <= 1'b0;
      end else if (count_wr.wr) begin
         block_q <= 1'b1;
      end else if (tick) begin
         block_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Overflow flag
   // ------------------------------------------------------------
   wire logic ovf_event = tick && !count_wr.wr &&
      (is_pc ? at_bottom : (is_fast ? at_top : at_max));
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         overflow_flag <= 1'b0;
      end else if (ovf_event) begin
         overflow_flag <= 1'b1;
      end else if (flag_clear_wr[2] || irq_ack[2]) begin
         overflow_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Compare channels
   // ------------------------------------------------------------
   logic [1:0] flag_q;
   logic [1:0] wave_q;
   wire tcu_wr_t cmp_wr [TCU_CHANNELS];
   assign cmp_wr[0] = compare_wr_a;
   assign cmp_wr[1] = compare_wr_b;
   wire logic update_point = is_fast ? (tick && at_top && !count_wr.wr) :
      (tick && at_bottom && !count_wr.wr);
   wire logic pc_update = is_pc && tick && at_top && !count_wr.wr;
   genvar ch;
   generate
      for (ch = 0; ch < TCU_CHANNELS; ch = ch + 1) begin : g_ch
         wire logic match = (count_q == active_q[ch]) && !block_q;
         wire logic match_tick = match && tick;
         wire logic forced = force_match_strobe[ch] && !is_pwm;
         wire logic upd = is_pwm && (is_pc ? pc_update : update_point);
         logic wave_d;
         always_comb begin
            wave_d = wave_q[ch];
            if ((match_tick && !is_pwm) || forced) begin
               case (action[ch])
                  TCU_OA_TOGGLE: wave_d = ~wave_q[ch];
                  TCU_OA_CLEAR: wave_d = 1'b0;
                  TCU_OA_SET: wave_d = 1'b1;
                  default: wave_d = wave_q[ch];
               endcase
            end else if (is_fast && action[ch][1]) begin
               if (match_tick) begin
                  wave_d = action[ch][0];
               end else if (tick && at_top && !count_wr.wr) begin
                  wave_d = ~action[ch][0];
               end
            end else if (is_pc && action[ch][1] && match_tick) begin
               wave_d = dir_down ? ~action[ch][0] : action[ch][0];
            end
         end
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               active_q[ch] <= TCU_RESET_COMPARE;
               buffer_q[ch] <= TCU_RESET_COMPARE;
               flag_q[ch] <= 1'b0;
               wave_q[ch] <= 1'b0;
            end else begin
               wave_q[ch] <= wave_d;
               if (cmp_wr[ch].wr) begin
                  buffer_q[ch] <= cmp_wr[ch].data;
               end
               if (cmp_wr[ch].wr && !is_pwm) begin
                  active_q[ch] <= cmp_wr[ch].data;
               end else if (upd) begin
                  active_q[ch] <= buffer_q[ch];
               end
               if (match_tick) begin
                  flag_q[ch] <= 1'b1;
               end else if (flag_clear_wr[ch] || irq_ack[ch]) begin
                  flag_q[ch] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count_value <= TCU_RESET_COUNT;
         compare_value_a <= TCU_RESET_COMPARE;
         compare_value_b <= TCU_RESET_COMPARE;
         match_flag_a <= 1'b0;
         match_flag_b <= 1'b0;
         irq_request <= 3'h0;
         wave_output_a <= 1'b0;
         wave_output_b <= 1'b0;
         count_down <= 1'b0;
      end else begin
         count_value <= count_d;
         compare_value_a <= is_pwm ? buffer_q[0] : active_q[0];
         compare_value_b <= is_pwm ? buffer_q[1] : active_q[1];
         match_flag_a <= flag_q[0];
         match_flag_b <= flag_q[1];
         irq_request <= {overflow_flag, flag_q} & irq_enable;
         wave_output_a <= wave_q[0];
         wave_output_b <= wave_q[1];
         count_down <= (dir_q == TCU_DIR_DOWN);
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_STOPPED_HOLDS: assert property (@(posedge clock) disable iff (!rst_n)
      (control_b.tick_source_select == TCU_SRC_NONE && !count_wr.wr) |=> $stable(count_q))
      else $error("count moved while stopped");
   AST_WRITE_WINS: assert property (@(posedge clock) disable iff (!rst_n)
      count_wr.wr |=> (count_q == $past(count_wr.data)))
      else $error("count write lost");
   AST_NORMAL_INC: assert property (@(posedge clock) disable iff (!rst_n)
      (tick && !count_wr.wr && waveform_mode == TCU_WM_NORMAL)
      |=> (count_q == $past(count_q) + 8'h01))
      else $error("normal mode did not increment");
   AST_FLAG_SET: assert property (@(posedge clock) disable iff (!rst_n)
      (tick && count_q == active_q[0] && !block_q) |=> flag_q[0])
      else $error("match flag a not set");
   AST_BLOCKED: assert property (@(posedge clock) disable iff (!rst_n)
      (block_q && tick && !flag_q[0]) |=> !flag_q[0])
      else $error("match not blocked after count write");
   AST_CLEAR_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
      (flag_clear_wr[0] && !(tick && count_q == active_q[0] && !block_q)) |=> !flag_q[0])
      else $error("flag clear ignored");
   AST_OVF_NORMAL: assert property (@(posedge clock) disable iff (!rst_n)
      (tick && !count_wr.wr && waveform_mode == TCU_WM_NORMAL && at_max) |=> overflow_flag)
      else $error("overflow not set at wrap");
   AST_NO_BUF_PWM: assert property (@(posedge clock) disable iff (!rst_n)
      (is_pwm && cmp_wr[1].wr && !g_ch[1].upd) |=> $stable(active_q[1]))
      else $error("active compare written directly in pwm");
   AST_FORCE_NO_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
      (force_match_strobe[1] && !is_pwm && action[1] == TCU_OA_SET && !flag_q[1] && !tick)
      |=> (wave_q[1] && !flag_q[1]))
      else $error("force strobe misbehaved");
   AST_CMP_TOP_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
      (tick && !count_wr.wr && top_is_cmp && !is_pc && at_top) |=> (count_q == TCU_BOTTOM))
      else $error("count not cleared at compare top");
   AST_MAX_TOP_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
      (tick && !count_wr.wr && waveform_mode == TCU_WM_FAST_MAX && at_max)
      |=> (count_q == TCU_BOTTOM))
      else $error("count not cleared at max top");
   AST_PC_DOWN: assert property (@(posedge clock) disable iff (!rst_n)
      (tick && !count_wr.wr && is_pc && dir_q == TCU_DIR_DOWN && !at_bottom)
      |=> (count_q == $past(count_q) - 8'h01))
      else $error("dual slope did not decrement");
   AST_PC_TURN: assert property (@(posedge clock) disable iff (!rst_n)
      (tick && !count_wr.wr && is_pc && at_top && !at_bottom) |=> (dir_q == TCU_DIR_DOWN))
      else $error("dual slope did not turn at top");
   AST_OVF_FAST: assert property (@(posedge clock) disable iff (!rst_n)
      (tick && !count_wr.wr && is_fast && at_top) |=> overflow_flag)
      else $error("overflow not set at fast top");
   AST_BUF_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
      g_ch[1].upd |=> (active_q[1] == $past(buffer_q[1])))
      else $error("buffered compare not loaded");
   AST_DIRECT_WR: assert property (@(posedge clock) disable iff (!rst_n)
      (!is_pwm && cmp_wr[0].wr) |=> (active_q[0] == $past(cmp_wr[0].data)))
      else $error("direct compare write lost");
   AST_FORCE_PWM_IGNORED: assert property (@(posedge clock) disable iff (!rst_n)
      (is_pwm && force_match_strobe[0] && !tick) |=> $stable(wave_q[0]))
      else $error("force acted in pwm mode");
   AST_WAVE_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
      (!tick && force_match_strobe == 2'h0) |=> $stable(wave_q))
      else $error("output state moved without event");
   AST_WAVE_RESET: assert property (@(posedge clock)
      !rst_n |=> (wave_q == 2'h0))
      else $error("output state not cleared by reset");
   AST_IRQ_REQ: assert property (@(posedge clock) disable iff (!rst_n)
      (flag_q[1] && irq_enable[1]) |=> irq_request[1])
      else $error("enabled flag gave no request");
   AST_ACK_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
      (irq_ack[1] && !g_ch[1].match_tick) |=> !flag_q[1])
      else $error("interrupt taken did not clear flag");
   AST_FLAG_B_SET: assert property (@(posedge clock) disable iff (!rst_n)
      (tick && count_q == active_q[1] && !block_q) |=> flag_q[1])
      else $error("match flag b not set");
   AST_BLOCK_SET: assert property (@(posedge clock) disable iff (!rst_n)
      count_wr.wr |=> block_q)
      else $error("count write did not arm blocking");
   AST_OVF_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
      (flag_clear_wr[2] && !ovf_event) |=> !overflow_flag)
      else $error("overflow clear ignored");
   AST_FORCE_KEEPS_COUNT: assert property (@(posedge clock) disable iff (!rst_n)
      (force_match_strobe != 2'h0 && !tick && !count_wr.wr) |=> $stable(count_q))
      else $error("force strobe moved the count");
   AST_COUNT_VISIBLE: assert property (@(posedge clock) disable iff (!rst_n)
      (count_value == count_q))
      else $error("count readback differs from counter");
endmodule
`default_nettype wire

// *** verif/tcu_host.sv ***
// Host model: takes timer interrupts and acknowledges them
`timescale 1ns/1ps
`default_nettype none
module tcu_host
   import tcu_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [2:0] irq_request,
   input wire logic [3:0] ack_delay,
   output logic [2:0] irq_ack
);
   logic [3:0] wait_q;
   initial irq_ack = 3'h0;
   initial wait_q = 4'h0;
   // Ack lowest pending request after ack_delay cycles
   always @(negedge clock) begin
      if (!rst_n || irq_request == 3'h0 || irq_ack != 3'h0) begin
         wait_q <= 4'h0;
         irq_ack <= 3'h0;
      end else if (wait_q < ack_delay) begin
         wait_q <= wait_q + 4'h1;
         irq_ack <= 3'h0;
      end else begin
         wait_q <= 4'h0;
         irq_ack <= irq_request & ~(irq_request - 3'h1);
      end
   end
endmodule
`default_nettype wire

// *** verif/tcu_timer8_test.sv ***
// Testbench: counting modes, flags, force and buffering of the timer
`timescale 1ns/1ps
`default_nettype none
module tcu_timer8_test
   import tcu_pkg::*;
   ;
   typedef struct packed {
      logic [2:0] m;
      logic [7:0] cmp, start, n, cnt;
      logic ov, fl, dn;
   } tcu_row_t;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic ext_tick = 1'b0;
   tcu_control_a_t control_a = '0;
   tcu_control_b_t control_b = '0;
   tcu_wr_t count_wr = '0, compare_wr_a = '0, compare_wr_b = '0;
   logic [1:0] force_match_strobe = 2'h0;
   logic [2:0] flag_clear_wr = 3'h0, irq_enable = 3'h0, irq_ack, irq_request;
   logic [3:0] ack_delay = 4'h9;
   logic [7:0] count_value, compare_value_a, compare_value_b;
   logic match_flag_a, match_flag_b, overflow_flag, wave_output_a, wave_output_b, count_down;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   tcu_row_t rows [7] = '{
      '{3'h0, 8'h30, 8'h20, 8'h05, 8'h25, 1'h0, 1'h0, 1'h0},
      '{3'h0, 8'h30, 8'hfe, 8'h03, 8'h01, 1'h1, 1'h0, 1'h0},
      '{3'h2, 8'h30, 8'h2e, 8'h04, 8'h01, 1'h0, 1'h1, 1'h0},
      '{3'h3, 8'h30, 8'hfd, 8'h04, 8'h01, 1'h1, 1'h0, 1'h0},
      '{3'h1, 8'h30, 8'hfd, 8'h04, 8'hfd, 1'h0, 1'h0, 1'h1},
      '{3'h7, 8'h40, 8'h3f, 8'h03, 8'h01, 1'h1, 1'h1, 1'h0},
      '{3'h5, 8'h40, 8'h3e, 8'h04, 8'h3e, 1'h0, 1'h1, 1'h1}};
   logic [1:0] acts [6] = '{2'h3, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
   logic outs [6] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};

   tcu_timer8 u_dut (.clock(clock), .rst_n(rst_n), .control_a(control_a),
      .control_b(control_b), .ext_tick(ext_tick), .count_wr(count_wr),
      .compare_wr_a(compare_wr_a), .compare_wr_b(compare_wr_b),
      .force_match_strobe(force_match_strobe), .flag_clear_wr(flag_clear_wr),
      .irq_enable(irq_enable), .irq_ack(irq_ack), .count_value(count_value),
      .compare_value_a(compare_value_a), .compare_value_b(compare_value_b),
      .match_flag_a(match_flag_a), .match_flag_b(match_flag_b),
      .overflow_flag(overflow_flag), .irq_request(irq_request),
      .wave_output_a(wave_output_a), .wave_output_b(wave_output_b),
      .count_down(count_down));
   tcu_host u_host (.clock(clock), .rst_n(rst_n), .irq_request(irq_request),
      .ack_delay(ack_delay), .irq_ack(irq_ack));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   initial forever #5 clock = ~clock;
   task automatic tally_and_finish();
      if (n_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_errors++;
         $display("[FAIL] %0t timeout", $time);
         tally_and_finish();
      end
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic mode(input logic [2:0] m, input logic [2:0] src);
      control_a.waveform_mode_bit1 = m[1];
      control_a.waveform_mode_bit0 = m[0];
      control_b.waveform_mode_bit2 = m[2];
      control_b.tick_source_select = src;
   endtask
   task automatic run(input logic [2:0] m, input int n);
      mode(m, TCU_SRC_DIRECT);
      tick(n);
      mode(m, TCU_SRC_NONE);
      tick(3);
   endtask
   task automatic wr(input int k, input logic [7:0] d);
      count_wr = {k == 0, d};
      compare_wr_a = {k == 1, d};
      compare_wr_b = {k == 2, d};
      tick(1);
      count_wr.wr = 1'b0;
      compare_wr_a.wr = 1'b0;
      compare_wr_b.wr = 1'b0;
   endtask
   task automatic clr(input logic [2:0] m);
      flag_clear_wr = m;
      tick(1);
      flag_clear_wr = 3'h0;
   endtask
   task automatic force_both();
      force_match_strobe = 2'h3;
      tick(1);
      force_match_strobe = 2'h0;
      tick(2);
   endtask
   task automatic src_chk(input logic [2:0] src, input int cyc, input logic [7:0] exp);
      mode(TCU_WM_NORMAL, TCU_SRC_NONE);
      wr(0, 8'h00);
      mode(TCU_WM_NORMAL, src);
      if (cyc > 0) begin
         tick(cyc);
      end else begin
         repeat (3) begin
            ext_tick = 1'b1;
            tick(1);
            ext_tick = 1'b0;
            tick(1);
         end
      end
      mode(TCU_WM_NORMAL, TCU_SRC_NONE);
      tick(1);
      chk8(count_value, exp);
   endtask

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      tick(20);
      rst_n = 1'b1;
      tick(1);
      chk8(count_value, TCU_RESET_COUNT);
      chk1(wave_output_a | wave_output_b, 1'b0);
      mode(TCU_WM_NORMAL, TCU_SRC_DIRECT);
      tick(3);
      wr(0, 8'h80);
      chk8(count_value, 8'h80);
      tick(1);
      chk8(count_value, 8'h81);
      mode(TCU_WM_NORMAL, TCU_SRC_NONE);
      wr(1, 8'h50);
      wr(0, 8'h50);
      tick(4);
      chk8(count_value, 8'h50);
      clr(3'h7);
      run(TCU_WM_NORMAL, 3);
      chk8(count_value, 8'h53);
      chk1(match_flag_a, 1'b0);
      foreach (rows[i]) begin
         mode(TCU_WM_NORMAL, TCU_SRC_NONE);
         wr(1, rows[i].cmp);
         wr(2, rows[i].cmp);
         wr(0, rows[i].start);
         clr(3'h7);
         chk8(compare_value_a, rows[i].cmp);
         run(rows[i].m, int'(rows[i].n));
         chk8(count_value, rows[i].cnt);
         chk1(overflow_flag, rows[i].ov);
         chk1(match_flag_a, rows[i].fl);
         chk1(match_flag_b, rows[i].fl);
         chk1(count_down, rows[i].dn);
      end
      clr(3'h4);
      tick(1);
      chk1(match_flag_a, 1'b1);
      clr(3'h1);
      tick(1);
      chk1(match_flag_a, 1'b0);
      irq_enable = 3'h2;
      tick(3);
      chk1(irq_request[1], 1'b1);
      tick(15);
      chk1(match_flag_b, 1'b0);
      irq_enable = 3'h0;
      mode(TCU_WM_NORMAL, TCU_SRC_NONE);
      wr(0, 8'h33);
      for (int k = 0; k < 6; k++) begin
         control_a.output_action_mode_a = acts[k];
         control_a.output_action_mode_b = acts[k];
         force_both();
         chk1(wave_output_a, outs[k]);
         chk1(wave_output_b, outs[k]);
      end
      chk1(match_flag_a, 1'b0);
      chk8(count_value, 8'h33);
      mode(TCU_WM_FAST_MAX, TCU_SRC_NONE);
      tick(2);
      chk1(wave_output_a, 1'b1);
      control_a.output_action_mode_a = TCU_OA_CLEAR;
      force_both();
      chk1(wave_output_a, 1'b1);
      mode(TCU_WM_NORMAL, TCU_SRC_NONE);
      wr(2, 8'h20);
      mode(TCU_WM_FAST_MAX, TCU_SRC_NONE);
      wr(2, 8'h60);
      tick(1);
      chk8(compare_value_b, 8'h60);
      wr(0, 8'h1e);
      clr(3'h7);
      run(TCU_WM_FAST_MAX, 6);
      chk1(match_flag_b, 1'b1);
      clr(3'h7);
      wr(0, 8'hfe);
      run(TCU_WM_FAST_MAX, 50);
      chk1(match_flag_b, 1'b0);
      run(TCU_WM_FAST_MAX, 52);
      chk1(match_flag_b, 1'b1);
      src_chk(TCU_SRC_DIV8, 2 * (int'(TCU_DIV8_MASK) + 1), 8'h02);
      src_chk(TCU_SRC_DIV64, 2 * (int'(TCU_DIV64_MASK) + 1), 8'h02);
      src_chk(TCU_SRC_DIV256, int'(TCU_DIV256_MASK) + 1, 8'h01);
      src_chk(TCU_SRC_DIV1024, int'(TCU_DIV1024_MASK) + 1, 8'h01);
      src_chk(TCU_SRC_EXT_RISE, 0, 8'h03);
      src_chk(TCU_SRC_EXT_FALL, 0, 8'h03);
      control_a.output_action_mode_a = TCU_OA_SET;
      control_a.output_action_mode_b = TCU_OA_SET;
      force_both();
      chk1(wave_output_a & wave_output_b, 1'b1);
      mode(TCU_WM_NORMAL, TCU_SRC_DIRECT);
      rst_n = 1'b0;
      tick(2);
      mode(TCU_WM_NORMAL, TCU_SRC_NONE);
      rst_n = 1'b1;
      tick(1);
      chk1(wave_output_a | wave_output_b, 1'b0);
      chk8(count_value, TCU_RESET_COUNT);
      tick(1);
      chk8(count_value, TCU_RESET_COUNT);
      chk1(overflow_flag, 1'b0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
